/* File: hw/internal_param_map.vh */
/*
 * Offsets, field positions, reset values and timing figures of the
 * internal-parameter measurement block.
 * Assumes a 125 MHz clock and a byte-addressed plain register port.
 */
`ifndef INTERNAL_PARAM_MAP_VH
`define INTERNAL_PARAM_MAP_VH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define OFS_CMD 8'h00
`define OFS_CFGB 8'h04
`define OFS_STACK_SUM 8'h08
`define OFS_DIE_TEMP 8'h0C
`define OFS_ANALOG_SUPPLY 8'h10
`define OFS_DIGITAL_SUPPLY 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1C

// ==========================================================
// Field positions
`define CMD_START_BIT 0
`define CMD_REDUNDANT_BIT 1
`define CMD_MODE_LSB 2
`define CMD_MODE_MSB 4
`define CMD_BUSY_BIT 0
`define CMD_STAGE_LSB 8
`define CMD_STAGE_MSB 10
`define CFGB_PS_LSB 0
`define CFGB_PS_MSB 1
`define CFGB_FORCE_BIT 2
`define IRQ_DONE_BIT 0
`define IRQ_FAULT_BIT 1

// ==========================================================
// Reset values
`define CFGB_RESET 3'h0
`define MODE_RESET 3'h0
`define IRQ_MASK_RESET 2'h0
`define RESULT_RESET 16'hFFFF

// ==========================================================
// Fault code layout
`define FAULT_UPPER 12'hFF0

// ==========================================================
// Timing: clock rate and milestone times in microseconds
`define CLK_MHZ 125
`define US_PER_TICK 1
`define TICK_CYCLES (`CLK_MHZ * `US_PER_TICK)
// Mode codes 0..7: 27kHz 14kHz 7kHz 3kHz 2kHz 1kHz 422Hz 26Hz
`define T1M_M0 18'd58
`define T2M_M0 18'd104
`define T3M_M0 18'd151
`define T4M_M0 18'd198
`define T4C_M0 18'd742
`define T1M_M1 18'd87
`define T2M_M1 18'd163
`define T3M_M1 18'd238
`define T4M_M1 18'd314
`define T4C_M1 18'd858
`define T1M_M2 18'd145
`define T2M_M2 18'd279
`define T3M_M2 18'd413
`define T4M_M2 18'd547
`define T4C_M2 18'd1556
`define T1M_M3 18'd261
`define T2M_M3 18'd512
`define T3M_M3 18'd762
`define T4M_M3 18'd1012
`define T4C_M3 18'd2022
`define T1M_M4 18'd494
`define T2M_M4 18'd977
`define T3M_M4 18'd1460
`define T4M_M4 18'd1943
`define T4C_M4 18'd2953
`define T1M_M5 18'd960
`define T2M_M5 18'd1908
`define T3M_M5 18'd2857
`define T4M_M5 18'd3805
`define T4C_M5 18'd4814
`define T1M_M6 18'd1890
`define T2M_M6 18'd3770
`define T3M_M6 18'd5649
`define T4M_M6 18'd7529
`define T4C_M6 18'd8538
`define T1M_M7 18'd29818
`define T2M_M7 18'd59624
`define T3M_M7 18'd89431
`define T4M_M7 18'd119238
`define T4C_M7 18'd134211

`endif

/* File: hw/internal_param_measure.v */
/*
 * Internal-parameter measurement sequencer with digital redundancy
 * checking, behind a plain register port.
 * Assumes a 125 MHz clock, a modulator bit stream synchronous to clk,
 * and a master that never issues read and write strobes together.
 */
`timescale 1ns/100ps
`include "internal_param_map.vh"

module internal_param_measure
#(
	parameter TICK_CYCLES = `TICK_CYCLES,
	parameter NUM_ADC = 3
)
(
	input wire clk,
	input wire rst_b,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire [NUM_ADC-1:0] mod_bit,
	output wire busy,
	output wire irq
);

// ==========================================================
// Register map seen by the host
// 0x00 command: write bit 0 starts, bit 1 picks the redundant variant,
//      bits 4:2 the mode; read gives busy, variant, mode and stage 10:8
// 0x04 configuration: path select in bits 1:0, force fail in bit 2
// 0x08 0x0C 0x10 0x14: stack sum, die temperature, analog and digital
//      supply results, 16 bits each, upper half reads zero
// 0x18 interrupt status, done in bit 0, fault in bit 1, read clears
// 0x1C interrupt mask of the same layout
// Unmapped reads give zero and unmapped writes are dropped.
// A start written while busy is ignored without any sign, so software
// should poll busy or wait for the done interrupt first.

// ==========================================================
// State encoding
localparam ST_IDLE = 1'b0;
localparam ST_RUN = 1'b1;

// Sequencer state
reg state;
reg [2:0] stage;
reg [2:0] mode;
reg redundant;
// Host configuration
reg [1:0] path_select;
reg force_fail;
// Interrupts
reg [1:0] irq_status;
reg [1:0] irq_mask;
// Result registers
reg [15:0] stack_sum_result;
reg [15:0] die_temp_result;
reg [15:0] analog_supply_result;
reg [15:0] digital_supply_result;
// Timing
reg [15:0] tick_div;
reg tick;
reg [17:0] elapsed;
// Integrators and comparison
reg [15:0] primary_acc [0:NUM_ADC-1];
reg [15:0] redundant_acc;
reg [1:0] covered_adc;
reg check_on;
reg [17:0] milestone;
reg [15:0] primary_val;
reg [15:0] redundant_val;
reg [15:0] next_result;
wire [3:0] nibble_fault;
reg slot_end;
reg seq_end;
wire start;
wire stat_read;

assign start = wr && addr == `OFS_CMD && wdata[`CMD_START_BIT];
assign stat_read = rd && addr == `OFS_IRQ_STATUS;
assign busy = state;
assign irq = |(irq_status & irq_mask);

// ==========================================================
// Milestone lookup, in microseconds from the start
always @*
begin
	case ({mode, stage})
	6'h00: milestone = `T1M_M0;
	6'h01: milestone = `T2M_M0;
	6'h02: milestone = `T3M_M0;
	6'h03: milestone = `T4M_M0;
	6'h04: milestone = `T4C_M0;
	6'h08: milestone = `T1M_M1;
	6'h09: milestone = `T2M_M1;
	6'h0A: milestone = `T3M_M1;
	6'h0B: milestone = `T4M_M1;
	6'h0C: milestone = `T4C_M1;
	6'h10: milestone = `T1M_M2;
	6'h11: milestone = `T2M_M2;
	6'h12: milestone = `T3M_M2;
	6'h13: milestone = `T4M_M2;
	6'h14: milestone = `T4C_M2;
	6'h18: milestone = `T1M_M3;
	6'h19: milestone = `T2M_M3;
	6'h1A: milestone = `T3M_M3;
	6'h1B: milestone = `T4M_M3;
	6'h1C: milestone = `T4C_M3;
	6'h20: milestone = `T1M_M4;
	6'h21: milestone = `T2M_M4;
	6'h22: milestone = `T3M_M4;
	6'h23: milestone = `T4M_M4;
	6'h24: milestone = `T4C_M4;
	6'h28: milestone = `T1M_M5;
	6'h29: milestone = `T2M_M5;
	6'h2A: milestone = `T3M_M5;
	6'h2B: milestone = `T4M_M5;
	6'h2C: milestone = `T4C_M5;
	6'h30: milestone = `T1M_M6;
	6'h31: milestone = `T2M_M6;
	6'h32: milestone = `T3M_M6;
	6'h33: milestone = `T4M_M6;
	6'h34: milestone = `T4C_M6;
	6'h38: milestone = `T1M_M7;
	6'h39: milestone = `T2M_M7;
	6'h3A: milestone = `T3M_M7;
	6'h3B: milestone = `T4M_M7;
	6'h3C: milestone = `T4C_M7;
	default: milestone = 18'h3FFFF;
	endcase
end

// ==========================================================
// Microsecond tick divider
// Held at zero while idle so the first tick comes a full period later
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		tick_div <= 16'h0000;
		tick <= 1'b0;
	end
	else if (state == ST_IDLE || tick_div == TICK_CYCLES[15:0] - 16'h0001)
	begin
		tick_div <= 16'h0000;
		tick <= state == ST_RUN;
	end
	else
	begin
		tick_div <= tick_div + 16'h0001;
		tick <= 1'b0;
	end
end

// ==========================================================
// Slot and sequence end detection
// A slot ends on the tick that reaches its milestone, so the whole
// run lasts exactly the total time in ticks
always @*
begin
	slot_end = state == ST_RUN && tick && elapsed + 18'h00001 >= milestone;
	seq_end = slot_end && stage == 3'h4;
end

// ==========================================================
// Covered path: automatic for 0/1, internal parameters on ADC0
// Paths 2 and 3 give no redundant cover to internal parameters,
// so the check stays off there
always @*
begin
	covered_adc = 2'h0;
	check_on = redundant && !path_select[1];
end

// ==========================================================
// Primary machines, one per ADC, integrating their bit streams
// Cleared at start and at each slot end; saturate rather than wrap
genvar g;
generate
	for (g = 0; g < NUM_ADC; g = g + 1)
	begin : prim
		always @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
				primary_acc[g] <= 16'h0000;
			else if (start && state == ST_IDLE || slot_end)
				primary_acc[g] <= 16'h0000;
			else if (state == ST_RUN && mod_bit[g] &&
				primary_acc[g] != 16'hFFFF)
				primary_acc[g] <= primary_acc[g] + 16'h0001;
		end
	end
endgenerate

// ==========================================================
// Shared redundant machine, fed the covered path's stream
// Counts only while the check is on, so a plain run leaves it idle
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
		redundant_acc <= 16'h0000;
	else if (start && state == ST_IDLE || slot_end)
		redundant_acc <= 16'h0000;
	else if (state == ST_RUN && check_on && mod_bit[covered_adc] &&
		redundant_acc != 16'hFFFF)
		redundant_acc <= redundant_acc + 16'h0001;
end

// ==========================================================
// Values compared at the end of each slot
always @*
begin
	primary_val = primary_acc[covered_adc];
	// Inverting gives a mismatch in every nibble whatever the counts
	redundant_val = force_fail ? ~redundant_acc : redundant_acc;
end

// ==========================================================
// Per-nibble mismatch flags, bit n covers result bits 4n+3..4n
generate
	for (g = 0; g < 4; g = g + 1)
	begin : nib
		assign nibble_fault[g] = primary_val[4*g+3 -: 4] !=
			redundant_val[4*g+3 -: 4];
	end
endgenerate

// ==========================================================
// Fault code substitution
always @*
begin
	// A code is written only when some nibble differs, so its low
	// four bits are never all zero
	if (check_on && |nibble_fault)
		next_result = {`FAULT_UPPER, nibble_fault};
	else
		next_result = primary_val;
end

// ==========================================================
// Sequencer: four slots then wait for the total time
// The stage stays at 4 after a run, showing that the tail finished
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		state <= ST_IDLE;
		stage <= 3'h0;
		elapsed <= 18'h00000;
		mode <= `MODE_RESET;
		redundant <= 1'b0;
	end
	else
	begin
		case (state)
		ST_IDLE:
		begin
			if (start)
			begin
				state <= ST_RUN;
				stage <= 3'h0;
				elapsed <= 18'h00000;
				mode <= wdata[`CMD_MODE_MSB:`CMD_MODE_LSB];
				redundant <= wdata[`CMD_REDUNDANT_BIT];
			end
		end
		ST_RUN:
		begin
			if (tick)
				elapsed <= elapsed + 18'h00001;
			if (seq_end)
				state <= ST_IDLE;
			else if (slot_end)
				stage <= stage + 3'h1;
		end
		default:
			state <= ST_IDLE;
		endcase
	end
end

// ==========================================================
// Result storage in status groups A and B
// Stage 4 is the tail up to the total time and stores nothing
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		stack_sum_result <= `RESULT_RESET;
		die_temp_result <= `RESULT_RESET;
		analog_supply_result <= `RESULT_RESET;
		digital_supply_result <= `RESULT_RESET;
	end
	else if (slot_end)
	begin
		case (stage)
		3'h0: stack_sum_result <= next_result;
		3'h1: die_temp_result <= next_result;
		3'h2: analog_supply_result <= next_result;
		3'h3: digital_supply_result <= next_result;
		default: ;
		endcase
	end
end

// ==========================================================
// Configuration and interrupt registers
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		// Path select and force fail share one reset value
		{force_fail, path_select} <= `CFGB_RESET;
		irq_mask <= `IRQ_MASK_RESET;
		irq_status <= 2'h0;
	end
	else
	begin
		if (wr && addr == `OFS_CFGB)
		begin
			path_select <= wdata[`CFGB_PS_MSB:`CFGB_PS_LSB];
			force_fail <= wdata[`CFGB_FORCE_BIT];
		end
		if (wr && addr == `OFS_IRQ_MASK)
			irq_mask <= wdata[1:0];
		// Set wins over the clear of a status read
		// Fault is flagged per faulted slot, never by the tail
		irq_status[`IRQ_DONE_BIT] <= seq_end ||
			irq_status[`IRQ_DONE_BIT] && !stat_read;
		irq_status[`IRQ_FAULT_BIT] <= slot_end && check_on &&
			stage != 3'h4 && |nibble_fault ||
			irq_status[`IRQ_FAULT_BIT] && !stat_read;
	end
end

// ==========================================================
// Read data, valid the cycle after the read strobe
// Zero when no read, so stale data never lingers on the bus
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
		rdata <= 32'h00000000;
	else if (rd)
	begin
		case (addr)
		`OFS_CMD: rdata <= {21'h0, stage, 3'h0, mode,
			redundant, state};
		`OFS_CFGB: rdata <= {29'h0, force_fail, path_select};
		`OFS_STACK_SUM: rdata <= {16'h0, stack_sum_result};
		`OFS_DIE_TEMP: rdata <= {16'h0, die_temp_result};
		`OFS_ANALOG_SUPPLY: rdata <= {16'h0, analog_supply_result};
		`OFS_DIGITAL_SUPPLY: rdata <= {16'h0, digital_supply_result};
		`OFS_IRQ_STATUS: rdata <= {30'h0, irq_status};
		`OFS_IRQ_MASK: rdata <= {30'h0, irq_mask};
		default: rdata <= 32'h00000000;
		endcase
	end
	else
		rdata <= 32'h00000000;
end

endmodule // internal_param_measure

/* File: tb/internal_param_chk.sv */
/* Port checker of the internal-parameter block, bound to its top.
   Assumes one clock and the register map header. */
`timescale 1ns/100ps
`include "internal_param_map.vh"
// ==========
// Checker
module internal_param_chk
#(
	parameter TICK_CYCLES = 125,
	parameter NUM_ADC = 3
)
(
	input wire clk,
	input wire rst_b,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	input wire [31:0] rdata,
	input wire [NUM_ADC-1:0] mod_bit,
	input wire busy,
	input wire irq
);
localparam int BMAX = 134211 * TICK_CYCLES + 8;
reg [1:0] mask;
reg plain;
int bcnt;
wire res_a = addr >= `OFS_STACK_SUM && addr <= `OFS_DIGITAL_SUPPLY;
wire go = wr && addr == `OFS_CMD && wdata[0] && !busy;
// Mask mirror, variant of last start, busy length
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
	begin
		mask <= 2'h0;
		plain <= 1'b1;
		bcnt <= 0;
	end
	else
	begin
		if (wr && addr == `OFS_IRQ_MASK)
			mask <= wdata[1:0];
		if (go)
			plain <= !wdata[1];
		bcnt <= busy ? bcnt + 1 : 0;
	end
end
default clocking @(posedge clk); endclocking
default disable iff (!rst_b);
// ==========
// Assertions
start_busy_a: assert property (go |=> busy)
	else $error("start not taken");
busy_min_a: assert property ($rose(busy) |-> busy [*8])
	else $error("run too short");
busy_max_a: assert property (bcnt <= BMAX)
	else $error("run too long");
irq_mask_a: assert property (irq |-> mask != 2'h0)
	else $error("irq while masked");
stat_clr_a: assert property (rd && addr == `OFS_IRQ_STATUS && !busy |=> !irq)
	else $error("status not cleared");
done_irq_a: assert property ($fell(busy) && mask[0] |-> ##[0:2] irq)
	else $error("no done irq");
rd_busy_a: assert property (rd && addr == `OFS_CMD |=>
	rdata[0] == $past(busy)) else $error("busy readback");
plain_ok_a: assert property (rd && res_a && plain |=>
	rdata[15:4] != 12'hFF0) else $error("fault in plain run");
fault_low_a: assert property (rd && res_a |=> rdata[3:0] != 4'h0 ||
	rdata[15:4] != `FAULT_UPPER) else $error("zero fault nibble");
cover property ($fell(busy));
cover property (rd && addr == `OFS_IRQ_STATUS && irq);
cover property (wr && addr == `OFS_CMD && wdata[0] && busy);
endmodule // internal_param_chk

bind internal_param_measure internal_param_chk
#(.TICK_CYCLES(TICK_CYCLES), .NUM_ADC(NUM_ADC)) i_chk (.clk(clk),
	.rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .mod_bit(mod_bit), .busy(busy), .irq(irq));

/* File: tb/internal_param_measure_redundancy_test.sv */
/* Bench of the internal-parameter block with a stream model.
   Assumes a tick shortened to two clocks. */
`timescale 1ns/100ps
`include "internal_param_map.vh"
// ==========
// Bench top
module internal_param_measure_redundancy_test;
localparam int TC = 2;
reg clk = 1'b0;
reg rst_b = 1'b0;
reg [7:0] addr = 8'h00;
reg [31:0] wdata = 32'h0;
reg wr = 1'b0;
reg rd = 1'b0;
reg ones = 1'b0;
wire [31:0] rdata;
wire [2:0] mod_bit;
wire busy;
wire irq;
int bad_count = 0;
int checks = 0;
reg [31:0] v;
int t4c [8] = '{742, 858, 1556, 2022, 2953, 4814, 8538, 134211};
// Clock of 8 ns
always #4 clk = ~clk;
internal_param_measure #(.TICK_CYCLES(TC)) i_dut (.clk(clk),
	.rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .mod_bit(mod_bit), .busy(busy), .irq(irq));
mod_stream_model i_mod (.clk(clk), .rst_b(rst_b), .ones(ones),
	.mod_bit(mod_bit));
// ==========
// Tasks
task chk(input [31:0] s, input [31:0] e, input string n);
	checks++;
	if (s !== e)
	begin
		bad_count++;
		$display("[ERR] %s expected %h seen %h", n, e, s);
	end
endtask
task wr_reg(input [7:0] a, input [31:0] dt);
	@(posedge clk);
	addr <= a;
	wdata <= dt;
	wr <= 1'b1;
	@(posedge clk);
	wr <= 1'b0;
endtask
task rd_reg(input [7:0] a, output [31:0] r);
	@(posedge clk);
	addr <= a;
	rd <= 1'b1;
	@(posedge clk);
	rd <= 1'b0;
	#1 r = rdata;
endtask
task run(input [31:0] c, input [15:0] e, input int t, input bit lz);
	int d;
	d = 0;
	wr_reg(`OFS_CMD, c);
	do
	begin
		@(posedge clk);
		#1 d++;
	end
	while (busy === 1'b1 && d < 300000);
	chk(32'(d >= t * TC && d <= t * TC + 3), 32'h1, "time");
	for (int i = 0; i < 4; i++)
	begin
		rd_reg(`OFS_STACK_SUM + 8'(4 * i), v);
		if (lz)
			chk(32'(v[15:12] != 4'hF && v != 0), 32'h1, "range");
		else
			chk(v, {16'h0, e}, "result");
	end
endtask
task stop_test();
	$display("checks %0d errors %0d", checks, bad_count);
	if (bad_count == 0 && checks > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
// Watchdog
initial
begin
	repeat (80000) @(posedge clk);
	bad_count++;
	stop_test();
end
// ==========
// Scenarios
initial
begin
	repeat (6) @(posedge clk);
	rst_b <= 1'b1;
	rd_reg(`OFS_CFGB, v);
	chk(v, 32'h0, "cfgb");
	rd_reg(`OFS_STACK_SUM, v);
	chk(v, 32'hFFFF, "sum");
	rd_reg(8'h20, v);
	chk(v, 32'h0, "unmapped");
	// Plain runs in modes 0 to 6, forced fail set
	wr_reg(`OFS_CFGB, 32'h4);
	wr_reg(`OFS_IRQ_MASK, 32'h1);
	for (int m = 0; m < 7; m++)
	begin
		run({27'h0, 3'(m), 2'h1}, 16'h0, t4c[m], 1'b0);
		chk({31'h0, irq}, 32'h1, "irq");
		rd_reg(`OFS_IRQ_STATUS, v);
		chk(v, 32'h1, "status");
		chk({31'h0, irq}, 32'h0, "irq clear");
	end
	// Redundant run on a busy stream, no forced fail
	ones <= 1'b1;
	wr_reg(`OFS_CFGB, 32'h0);
	run(32'h3, 16'h0, t4c[0], 1'b1);
	rd_reg(`OFS_CMD, v);
	chk(v, 32'h402, "cmd after run");
	// Forced fail on path 1
	ones <= 1'b0;
	wr_reg(`OFS_CFGB, 32'h5);
	wr_reg(`OFS_IRQ_MASK, 32'h3);
	run(32'h3, 16'hFF0F, t4c[0], 1'b0);
	rd_reg(`OFS_IRQ_STATUS, v);
	chk(v, 32'h3, "status");
	// Path 2 leaves the check off; mask hides done
	wr_reg(`OFS_CFGB, 32'h6);
	wr_reg(`OFS_IRQ_MASK, 32'h0);
	run(32'h3, 16'h0, t4c[0], 1'b0);
	chk({31'h0, irq}, 32'h0, "irq masked");
	rd_reg(`OFS_IRQ_STATUS, v);
	chk(v, 32'h1, "status");
	// Slowest mode, a refused start, reset mid-run
	wr_reg(`OFS_CMD, 32'h1F);
	wr_reg(`OFS_CMD, 32'h1);
	rd_reg(`OFS_CMD, v);
	chk(v, 32'h1F, "cmd");
	@(posedge clk);
	rst_b <= 1'b0;
	repeat (2) @(posedge clk);
	rst_b <= 1'b1;
	rd_reg(`OFS_CMD, v);
	chk(v, 32'h0, "cmd reset");
	rd_reg(`OFS_STACK_SUM, v);
	chk(v, 32'hFFFF, "sum reset");
	stop_test();
end
endmodule // internal_param_measure_redundancy_test

/* File: tb/mod_stream_model.sv */
/* Modulator bit-stream source at the far side of the block.
   Assumes the bench picks the density; bits change after clk. */
`timescale 1ns/100ps
// ==========
// Stream source
module mod_stream_model
(
	input wire clk,
	input wire rst_b,
	input wire ones,
	output reg [2:0] mod_bit
);
// All three modulators emit one bit per clock
always @(posedge clk or negedge rst_b)
begin
	if (!rst_b)
		mod_bit <= 3'h0;
	else
		mod_bit <= {3{ones}};
end
endmodule // mod_stream_model
